// file: ipe_engine.sv
`timescale 1ns/1ps
module ipe_engine #(
  parameter logic [6:0] SLV_ADDR = ipe_pkg::ADDR_RST // Own address
) (
  input  wire logic       clk_in,           // System clock
  input  wire logic       resetn_in,        // Sync reset, active low
  input  wire logic       link_clk_in,      // Link-side clock
  input  wire logic       scl_in,           // SCL wire level
  output logic            scl_out,          // SCL drive value
  output logic            scl_oe_out,       // SCL pulled low
  input  wire logic       sda_in,           // SDA wire level
  output logic            sda_out,          // SDA drive value
  output logic            sda_oe_out,       // SDA pulled low
  input  wire logic       cmd_valid_in,     // Command request
  input  wire logic [1:0] cmd_in,           // Command code
  input  wire logic [7:0] cmd_data_in,      // Address or data byte
  input  wire logic       cmd_nack_in,      // Read: answer not-ack
  output logic            cmd_ready_out,    // Command accepted when high
  output logic            done_out,         // Command finished pulse
  output logic [7:0]      rx_data_out,      // Byte read by master
  output logic            nack_out,         // No acknowledge seen
  output logic            arb_lost_out,     // Arbitration lost
  output logic            bus_busy_out,     // Bus active
  input  wire logic       slv_tx_load_in,   // Load slave send byte
  input  wire logic [7:0] slv_tx_data_in,   // Slave send byte
  output logic            slv_rx_valid_out, // Slave byte pulse
  output logic [7:0]      slv_rx_data_out   // Slave received byte
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [2:0]       lr;        // Link reset synchroniser
  logic             lrst_n;    // Link reset, active low
  logic [3:0]       ls1, ls2, ls3, lf, lq;
  logic [2:0]       cs1, cs2, cs3, cf, cq;
  logic             scl_f, sda_f, scl_p, sda_p;
  logic             start_det, stop_det, low_seen, busy;
  logic             new_cmd, rise, fall;
  logic             c_req, t_tgl;
  logic [1:0]       c_cmd;
  logic [7:0]       c_data, t_data;
  logic             c_nack;
  ipe_pkg::ipe_mst_t mst;
  logic [1:0]       ph;
  logic [7:0]       cnt;
  logic             tmo;
  logic [3:0]       bitn;
  logic [7:0]       msh, mrx, l_rx;
  logic             rd, m_nack, own, m_sda_oe;
  logic             l_done, l_nack, l_lost;
  logic             v_bit, m_tx;
  ipe_pkg::ipe_sst_t sst;
  logic [3:0]       sbit;
  logic [7:0]       ssh, s_txb, s_byte;
  logic             s_rw, s_oe, s_mack, s_tgl;

  // ****************************************
  // Link clock: reset and input synchronisers
  // ****************************************
  // Reset release enters the link domain through three flops
  always_ff @(posedge link_clk_in) begin
    lr <= {lr[1:0], resetn_in};
  end
  assign lrst_n = lr[1] & lr[2];

  // Pins and toggles: a change counts when stages two and three agree
  always_ff @(posedge link_clk_in) begin
    ls1 <= {scl_in, sda_in, c_req, t_tgl};
    ls2 <= ls1;
    ls3 <= ls2;
  end

  always_ff @(posedge link_clk_in) begin
    if (!lrst_n) begin
      lf <= ipe_pkg::LINK_FRST;
      lq <= ipe_pkg::LINK_FRST;
    end else begin
      lf <= (~(ls2 ^ ls3) & ls3) | ((ls2 ^ ls3) & lf);
      lq <= lf;
    end
  end

  assign scl_f   = lf[3];
  assign sda_f   = lf[2];
  assign scl_p   = lq[3];
  assign sda_p   = lq[2];
  assign new_cmd = lf[1] ^ lq[1];
  assign rise    = scl_f & ~scl_p;
  assign fall    = ~scl_f & scl_p;
  // Conditions are SDA edges while SCL stays high
  assign start_det = scl_f & scl_p & sda_p & ~sda_f;
  assign stop_det  = scl_f & scl_p & ~sda_p & sda_f & low_seen;

  // ****************************************
  // Bus monitor
  // ****************************************
  // Busy from Start until a Stop; idle otherwise
  always_ff @(posedge link_clk_in) begin
    if (!lrst_n) begin
      busy     <= 1'b0;
      low_seen <= 1'b0;
    end else begin
      if (start_det) begin
        busy     <= 1'b1;
        low_seen <= 1'b0;
      end else if (!scl_f) begin
        low_seen <= 1'b1;
      end
      if (stop_det) begin
        busy <= 1'b0;
      end
    end
  end

  // ****************************************
  // Master engine
  // ****************************************
  // Level presented in this bit, and whether this master sends it
  assign v_bit = (bitn == ipe_pkg::ACK_BIT) ? (rd ? m_nack : 1'b1)
                                            : (rd ? 1'b1 : msh[7]);
  assign m_tx  = (bitn == ipe_pkg::ACK_BIT) == rd;
  assign tmo   = cnt == ipe_pkg::HALF_LAST;

  // Start, byte, Stop sequencing with stretch wait and arbitration
  always_ff @(posedge link_clk_in) begin
    if (!lrst_n) begin
      mst        <= ipe_pkg::M_IDLE;
      ph         <= 2'h0;
      cnt        <= 8'h00;
      bitn       <= 4'h0;
      msh        <= 8'h00;
      mrx        <= 8'h00;
      rd         <= 1'b0;
      m_nack     <= 1'b0;
      own        <= 1'b0;
      scl_oe_out <= 1'b0;
      m_sda_oe   <= 1'b0;
      l_done     <= 1'b0;
      l_nack     <= 1'b0;
      l_lost     <= 1'b0;
      l_rx       <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
      case (mst)
        ipe_pkg::M_IDLE: begin
          if (new_cmd) begin
            l_lost <= 1'b0;
            l_nack <= 1'b0;
            cnt    <= 8'h00;
            ph     <= 2'h0;
            bitn   <= 4'h0;
            msh    <= c_data;
            m_nack <= c_nack;
            if (!own && c_cmd != ipe_pkg::CMD_START) begin
              l_lost <= 1'b1;
              l_done <= ~l_done;
            end else if (c_cmd == ipe_pkg::CMD_START) begin
              mst <= ipe_pkg::M_START;
            end else if (c_cmd == ipe_pkg::CMD_STOP) begin
              mst <= ipe_pkg::M_STOP;
            end else begin
              rd  <= c_cmd == ipe_pkg::CMD_READ;
              mst <= ipe_pkg::M_BIT;
            end
          end
        end
        ipe_pkg::M_START: begin
          case (ph)
            2'h0: begin
              m_sda_oe <= 1'b0;
              if (!own && busy) begin
                cnt <= 8'h00;
              end else if (tmo) begin
                scl_oe_out <= 1'b0;
                ph         <= 2'h1;
                cnt        <= 8'h00;
              end
            end
            2'h1: begin
              cnt <= 8'h00;
              if (scl_f) begin
                ph <= 2'h2;
              end
            end
            2'h2: begin
              if (tmo) begin
                cnt <= 8'h00;
                ph  <= 2'h3;
                if (!sda_f) begin
                  own    <= 1'b0;
                  l_lost <= 1'b1;
                  l_done <= ~l_done;
                  mst    <= ipe_pkg::M_IDLE;
                end else begin
                  m_sda_oe <= 1'b1;
                end
              end
            end
            default: begin
              if (tmo) begin
                scl_oe_out <= 1'b1;
                own        <= 1'b1;
                rd         <= 1'b0;
                ph         <= 2'h0;
                cnt        <= 8'h00;
                mst        <= ipe_pkg::M_BIT;
              end
            end
          endcase
        end
        ipe_pkg::M_BIT: begin
          case (ph)
            2'h0: begin
              // Move SDA only once SCL reads low, never while it is high
              if (!scl_f) begin
                m_sda_oe <= ~v_bit;
              end
              if (tmo) begin
                scl_oe_out <= 1'b0;
                ph         <= 2'h1;
                cnt        <= 8'h00;
              end
            end
            2'h1: begin
              cnt <= 8'h00;
              if (scl_f) begin
                ph <= 2'h2;
                if (bitn != ipe_pkg::ACK_BIT) begin
                  mrx <= {mrx[6:0], sda_f};
                end else if (!rd) begin
                  l_nack <= sda_f;
                end
                if (m_tx && v_bit && !sda_f) begin
                  scl_oe_out <= 1'b0;
                  m_sda_oe   <= 1'b0;
                  own        <= 1'b0;
                  l_lost     <= 1'b1;
                  l_done     <= ~l_done;
                  mst        <= ipe_pkg::M_IDLE;
                end
              end
            end
            default: begin
              if (tmo) begin
                scl_oe_out <= 1'b1;
                cnt        <= 8'h00;
                ph         <= 2'h0;
                msh        <= {msh[6:0], 1'b0};
                bitn       <= bitn + 4'h1;
                if (bitn == ipe_pkg::ACK_BIT) begin
                  m_sda_oe <= 1'b0;
                  l_rx     <= mrx;
                  l_done   <= ~l_done;
                  mst      <= ipe_pkg::M_IDLE;
                end
              end
            end
          endcase
        end
        default: begin
          case (ph)
            2'h0: begin
              m_sda_oe <= 1'b1;
              if (tmo) begin
                scl_oe_out <= 1'b0;
                ph         <= 2'h1;
                cnt        <= 8'h00;
              end
            end
            2'h1: begin
              cnt <= 8'h00;
              if (scl_f) begin
                ph <= 2'h2;
              end
            end
            2'h2: begin
              if (tmo) begin
                m_sda_oe <= 1'b0;
                ph       <= 2'h3;
                cnt      <= 8'h00;
              end
            end
            default: begin
              if (tmo) begin
                own    <= 1'b0;
                l_done <= ~l_done;
                mst    <= ipe_pkg::M_IDLE;
              end
            end
          endcase
        end
      endcase
    end
  end

  // ****************************************
  // Slave engine
  // ****************************************
  // Address match, receive with acknowledge, or send on read
  always_ff @(posedge link_clk_in) begin
    if (!lrst_n) begin
      sst    <= ipe_pkg::S_IDLE;
      sbit   <= 4'h0;
      ssh    <= 8'h00;
      s_rw   <= 1'b0;
      s_oe   <= 1'b0;
      s_mack <= 1'b1;
      s_tgl  <= 1'b0;
      s_byte <= 8'h00;
      s_txb  <= 8'h00;
    end else begin
      if (lf[0] ^ lq[0]) begin
        s_txb <= t_data;
      end
      // The SCL fall that closes a Start is no data edge: count from -1
      if (start_det) begin
        sst  <= ipe_pkg::S_ADDR;
        sbit <= 4'hF;
        s_oe <= 1'b0;
      end else if (stop_det) begin
        sst  <= ipe_pkg::S_IDLE;
        s_oe <= 1'b0;
      end else if (sst != ipe_pkg::S_IDLE && rise) begin
        if (sbit != ipe_pkg::ACK_BIT) begin
          ssh <= {ssh[6:0], sda_f};
        end else begin
          s_mack <= sda_f;
        end
      end else if (sst != ipe_pkg::S_IDLE && fall) begin
        sbit <= sbit + 4'h1;
        if (sbit == ipe_pkg::LAST_DATA) begin
          if (sst == ipe_pkg::S_TX) begin
            s_oe <= 1'b0;
          end else if (sst == ipe_pkg::S_RX) begin
            s_oe   <= 1'b1;
            s_byte <= ssh;
            s_tgl  <= ~s_tgl;
          end else if (ssh[7:1] == SLV_ADDR) begin
            s_oe <= 1'b1;
            s_rw <= ssh[0];
          end else begin
            sst <= ipe_pkg::S_IDLE;
          end
        end else if (sbit == ipe_pkg::ACK_BIT) begin
          sbit <= 4'h0;
          s_oe <= 1'b0;
          if (sst == ipe_pkg::S_RX) begin
            sst <= ipe_pkg::S_RX;
          end else if (sst == ipe_pkg::S_ADDR && !s_rw) begin
            sst <= ipe_pkg::S_RX;
          end else if (sst == ipe_pkg::S_ADDR || !s_mack) begin
            sst  <= ipe_pkg::S_TX;
            ssh  <= s_txb;
            s_oe <= ~s_txb[7];
          end else begin
            sst <= ipe_pkg::S_IDLE;
          end
        end else if (sst == ipe_pkg::S_TX) begin
          // The rise already rotated the byte, next bit sits on top
          s_oe <= ~ssh[7];
        end
      end
    end
  end

  // Open-drain pins: only ever drive low
  always_ff @(posedge link_clk_in) begin
    if (!lrst_n) begin
      sda_oe_out <= 1'b0;
      scl_out    <= 1'b0;
      sda_out    <= 1'b0;
    end else begin
      sda_oe_out <= m_sda_oe | s_oe;
      scl_out    <= 1'b0;
      sda_out    <= 1'b0;
    end
  end

  // ****************************************
  // System clock side
  // ****************************************
  // Link toggles and busy level through three flops
  always_ff @(posedge clk_in) begin
    cs1 <= {l_done, s_tgl, busy};
    cs2 <= cs1;
    cs3 <= cs2;
  end

  // Command handshake, results and slave bytes
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cf               <= 3'h0;
      cq               <= 3'h0;
      c_req            <= 1'b0;
      c_cmd            <= 2'h0;
      c_data           <= 8'h00;
      c_nack           <= 1'b0;
      t_tgl            <= 1'b0;
      t_data           <= 8'h00;
      cmd_ready_out    <= 1'b1;
      done_out         <= 1'b0;
      rx_data_out      <= 8'h00;
      nack_out         <= 1'b0;
      arb_lost_out     <= 1'b0;
      bus_busy_out     <= 1'b0;
      slv_rx_valid_out <= 1'b0;
      slv_rx_data_out  <= 8'h00;
    end else begin
      cf <= (~(cs2 ^ cs3) & cs3) | ((cs2 ^ cs3) & cf);
      cq <= cf;
      bus_busy_out     <= cf[0];
      done_out         <= cf[2] ^ cq[2];
      slv_rx_valid_out <= cf[1] ^ cq[1];
      if (cf[1] ^ cq[1]) begin
        slv_rx_data_out <= s_byte;
      end
      if (cf[2] ^ cq[2]) begin
        rx_data_out   <= l_rx;
        nack_out      <= l_nack;
        arb_lost_out  <= l_lost;
        cmd_ready_out <= 1'b1;
      end
      if (cmd_valid_in && cmd_ready_out) begin
        c_cmd         <= cmd_in;
        c_data        <= cmd_data_in;
        c_nack        <= cmd_nack_in;
        c_req         <= ~c_req;
        cmd_ready_out <= 1'b0;
      end
      if (slv_tx_load_in) begin
        t_data <= slv_tx_data_in;
        t_tgl  <= ~t_tgl;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_start_busy: assert property (@(posedge link_clk_in)
    disable iff (!lrst_n) start_det |=> busy)
    else $error("busy not set after start");
  chk_stop_after_low: assert property (@(posedge link_clk_in)
    disable iff (!lrst_n) stop_det |-> low_seen ##1 !busy)
    else $error("stop without SCL low or busy held");
  chk_start_edge: assert property (@(posedge link_clk_in)
    disable iff (!lrst_n)
    (mst == ipe_pkg::M_START && $rose(m_sda_oe)) |-> scl_f)
    else $error("start SDA fall without SCL high");
  chk_data_scl_low: assert property (@(posedge link_clk_in)
    disable iff (!lrst_n)
    (mst == ipe_pkg::M_BIT && $changed(m_sda_oe)) |-> !scl_f)
    else $error("data SDA changed with SCL high");
  chk_arb_release: assert property (@(posedge link_clk_in)
    disable iff (!lrst_n)
    (mst == ipe_pkg::M_BIT && ph == 2'h1 && scl_f && m_tx && v_bit
     && !sda_f) |=> !scl_oe_out && !m_sda_oe && !own)
    else $error("lines held after arbitration loss");
  chk_ack_release: assert property (@(posedge link_clk_in)
    disable iff (!lrst_n)
    (mst == ipe_pkg::M_BIT && bitn == ipe_pkg::ACK_BIT && !rd
     && ph == 2'h1) |-> !m_sda_oe)
    else $error("master held SDA in write ack slot");
  chk_stretch_wait: assert property (@(posedge link_clk_in)
    disable iff (!lrst_n)
    (mst == ipe_pkg::M_BIT && ph == 2'h1 && !scl_f) |=>
    ph == 2'h1 && !scl_oe_out)
    else $error("master moved on while SCL held low");
  chk_slave_reset: assert property (@(posedge link_clk_in)
    disable iff (!lrst_n)
    start_det |=> sst == ipe_pkg::S_ADDR && sbit == 4'hF && !s_oe)
    else $error("slave not reset by start");
  chk_slave_ack: assert property (@(posedge link_clk_in)
    disable iff (!lrst_n)
    (sst == ipe_pkg::S_RX && fall && !start_det && !stop_det
     && sbit == ipe_pkg::LAST_DATA) |=> s_oe [*1] ##1 sda_oe_out)
    else $error("slave did not acknowledge byte");
  chk_cmd_taken: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    (cmd_valid_in && cmd_ready_out) |=> !cmd_ready_out ##1 !done_out)
    else $error("command not held pending");

endmodule // ipe_engine

// file: ipe_pkg.sv
package ipe_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int         CLK_PERIOD_NS  = 8;    // System clock period
  localparam int         LINK_PERIOD_NS = 125;  // Link clock period
  localparam int         T_HALF_NS      = 5000; // Least SCL half period
  // Least time, rounded up to whole link cycles
  localparam logic [7:0] HALF_CYC  =
    8'((T_HALF_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [7:0] HALF_LAST = HALF_CYC - 8'h01;

  // ****************************************
  // Byte framing and reset values
  // ****************************************
  localparam logic [3:0] ACK_BIT   = 4'h8; // Ninth bit of a segment
  localparam logic [3:0] LAST_DATA = 4'h7; // Eighth bit of a segment
  localparam logic [3:0] LINK_FRST = 4'hC; // SCL, SDA idle high
  localparam logic [6:0] ADDR_RST  = 7'h2A; // Own slave address

  // ****************************************
  // Commands and states
  // ****************************************
  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ  = 2'h2,
    CMD_STOP  = 2'h3
  } ipe_cmd_t;

  typedef enum logic [3:0] {
    M_IDLE  = 4'h1,
    M_START = 4'h2,
    M_BIT   = 4'h4,
    M_STOP  = 4'h8
  } ipe_mst_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_ADDR = 4'h2,
    S_RX   = 4'h4,
    S_TX   = 4'h8
  } ipe_sst_t;

endpackage

// file: ipe_far_slave.sv
`timescale 1ns/1ps
// ****************************************
// Far-side slave on the two-wire bus
// ****************************************
module ipe_far_slave #(
  parameter logic [6:0] ADDR = 7'h50 // Model address
) (
  input  wire logic       scl_in,     // SCL wire level
  input  wire logic       sda_in,     // SDA wire level
  input  wire logic       stretch_in, // Stretch after ack
  output logic            scl_oe_out, // Pull SCL low
  output logic            sda_oe_out, // Pull SDA low
  output logic [7:0]      rx_out      // Last data byte
);
  int         cnt = 0;
  logic       act = 1'b0;
  logic       first = 1'b0;
  logic       sel = 1'b0;
  logic [7:0] sh = 8'h00;

  // Lines released, pull-ups set the level
  initial begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
    rx_out = 8'h00;
  end
  // Start or repeated Start rearms the byte counter
  always @(negedge sda_in) if (scl_in === 1'b1) begin
    cnt = 0;
    act = 1'b1;
    first = 1'b1;
    sel = 1'b0;
  end
  // Stop frees the model
  always @(posedge sda_in) if (scl_in === 1'b1) act = 1'b0;
  // Shift on rising SCL, most significant bit first
  always @(posedge scl_in) if (act && cnt < 8) begin
    sh = {sh[6:0], sda_in};
    cnt++;
  end
  // Ack from 8th to 9th falling edge, then optional stretch
  always @(negedge scl_in) if (act) begin
    if (cnt == 8) begin
      if (first) sel = (sh == {ADDR, 1'b0});
      else if (sel) rx_out = sh;
      sda_oe_out = sel;
      first = 1'b0;
      cnt = 9;
    end else if (cnt == 9) begin
      sda_oe_out = 1'b0;
      cnt = 0;
      if (sel && stretch_in) begin
        scl_oe_out = 1'b1;
        // Longer than the master's low half, so the master must wait
        #8000 scl_oe_out = 1'b0;
      end
    end
  end
endmodule // ipe_far_slave

// file: tb_top.sv
`timescale 1ns/1ps
// ****************************************
// Engine bench with far-side slave model
// ****************************************
module tb_top;
  logic       clk_in = 1'b0;
  logic       link_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       valid = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic [7:0] data = 8'h00;
  logic       nk = 1'b0;
  logic       load = 1'b0;
  logic [7:0] tx = 8'h00;
  logic [7:0] lfsr = 8'h18;
  logic       jam = 1'b0;
  logic       d_scl_oe, d_sda_oe, m_scl_oe, m_sda_oe;
  logic       ready, done, nack, arb;
  logic       busy_o, srx_v, scl_o, sda_o;
  logic [7:0] rx, m_rx, srx_d;
  logic [9:0] exp_q[$];
  logic [9:0] msk_q[$];
  logic [7:0] srx_q[$];
  int         num_errors = 0;
  int         n_tests = 0;
  wire        scl = ~(d_scl_oe | m_scl_oe);
  wire        sda = ~(d_sda_oe | m_sda_oe | jam);

  // System and link clocks
  always #4 clk_in = ~clk_in;
  always #62.5 link_clk = ~link_clk;

  // Own slave shares the model's address, so both answer a write; the model ignores reads
  ipe_engine #(.SLV_ADDR(7'h50)) u_dut (.clk_in(clk_in), .resetn_in(resetn),
    .link_clk_in(link_clk), .scl_in(scl), .scl_out(scl_o),
    .scl_oe_out(d_scl_oe), .sda_in(sda), .sda_out(sda_o),
    .sda_oe_out(d_sda_oe), .cmd_valid_in(valid), .cmd_in(cmd),
    .cmd_data_in(data), .cmd_nack_in(nk), .cmd_ready_out(ready),
    .done_out(done), .rx_data_out(rx), .nack_out(nack),
    .arb_lost_out(arb), .bus_busy_out(busy_o), .slv_tx_load_in(load),
    .slv_tx_data_in(tx), .slv_rx_valid_out(srx_v),
    .slv_rx_data_out(srx_d));

  ipe_far_slave #(.ADDR(7'h50)) u_far (.scl_in(scl), .sda_in(sda),
    .stretch_in(1'b1), .scl_oe_out(m_scl_oe), .sda_oe_out(m_sda_oe),
    .rx_out(m_rx));

  function automatic logic [7:0] step(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic check(input logic [9:0] seen, input logic [9:0] want);
    n_tests++;
    if (seen !== want) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  task automatic summarize();
    if (exp_q.size() != 0 || srx_q.size() != 0) num_errors++;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Hold a command until taken, note the result, wait for done
  task automatic issue(input logic [1:0] c, input logic [7:0] d,
                       input logic k, input logic [9:0] e,
                       input logic [9:0] m);
    int i;
    exp_q.push_back(e);
    msk_q.push_back(m);
    cmd = c;
    data = d;
    nk = k;
    valid = 1'b1;
    while (ready !== 1'b1) begin
      @(posedge clk_in);
      #1;
    end
    @(posedge clk_in);
    #1 valid = 1'b0;
    i = 0;
    while (done !== 1'b1 && i < 60000) begin
      @(posedge clk_in);
      #1 i++;
    end
    @(posedge clk_in);
    #1;
  endtask

  // Compare each finished command with the oldest note
  always @(negedge clk_in) if (done === 1'b1) begin
    if (exp_q.size() == 0) check(10'h3FF, 10'h000);
    else check({arb, nack, rx} & msk_q.pop_front(),
               exp_q.pop_front());
  end

  // Compare each byte taken by the engine's own slave with its note
  always @(negedge clk_in) if (srx_v === 1'b1) begin
    if (srx_q.size() == 0) check(10'h3FF, 10'h000);
    else check({2'h0, srx_d}, {2'h0, srx_q.pop_front()});
  end

  // Watchdog
  initial begin
    #780000;
    num_errors++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge link_clk);
    @(posedge clk_in);
    #1 resetn = 1'b1;
    repeat (5) @(posedge link_clk);
    @(posedge clk_in);
    #1 lfsr = step(lfsr);
    tx = lfsr;
    load = 1'b1;
    @(posedge clk_in);
    #1 load = 1'b0;
    lfsr = step(lfsr);
    // Write to model and own slave at once, with stretching
    issue(ipe_pkg::CMD_START, 8'hA0, 1'b0, 10'h000, 10'h300);
    check({9'h000, busy_o}, 10'h001);
    srx_q.push_back(lfsr);
    issue(ipe_pkg::CMD_WRITE, lfsr, 1'b0, 10'h000, 10'h300);
    check({2'h0, m_rx}, {2'h0, lfsr});
    // A rival pulls SDA low on a high data bit, then sends a Stop
    jam = 1'b1;
    issue(ipe_pkg::CMD_WRITE, 8'hFF, 1'b0, 10'h200, 10'h300);
    jam = 1'b0;
    issue(ipe_pkg::CMD_START, 8'h66, 1'b0, 10'h100, 10'h300);
    // Read own slave twice, not-ack the last byte, then Stop
    issue(ipe_pkg::CMD_START, 8'hA1, 1'b0, 10'h000, 10'h300);
    issue(ipe_pkg::CMD_READ, 8'h00, 1'b0, {2'h0, tx}, 10'h2FF);
    issue(ipe_pkg::CMD_READ, 8'h00, 1'b1, {2'h0, tx}, 10'h2FF);
    issue(ipe_pkg::CMD_STOP, 8'h00, 1'b0, 10'h000, 10'h200);
    check({9'h000, busy_o}, 10'h000);
    check({8'h00, scl_o, sda_o}, 10'h000);
    // Write without owning the bus is refused
    issue(ipe_pkg::CMD_WRITE, lfsr, 1'b0, 10'h200, 10'h200);
    summarize();
  end
endmodule // tb_top
